//--- logic/psram_link.sv
`timescale 1ns/100ps
// Functional notes
// - Select falling starts, rising ends transaction
// - Bus clock may stop between edges
// - Single-ended uses true clock only
// - Centered option times strobe from shifted clock
// - Shifted clock ignored during writes
// - Differential uses shifted pair, else true
// - Reads toggle strobe on bus clock edges, or on shifted clock edges with the centered option
// - Write strobe acts as byte mask
// - Strobe shows extra latency at start
// - Doubled latency always required
// - Reset low releases strobe and data
module psram_link #(
	parameter int WORDS = psram_pkg::MEM_WORDS,
	parameter int DEPTH = psram_pkg::FIFO_DEPTH
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          bus_clock,
	input  wire logic                          bus_clock_comp,
	input  wire logic                          shifted_clock,
	input  wire logic                          shifted_clock_comp,
	input  wire logic                          select_n,
	input  wire logic                          diff_clock_en,
	input  wire logic                          centered_read_strobe_option,
	input  wire logic [psram_pkg::DATA_W-1:0]  dq_i,
	input  wire logic                          rw_data_strobe_i,
	output logic      [psram_pkg::DATA_W-1:0]  dq_o,
	output logic                               dq_oe_n,
	output logic                               rw_data_strobe_o,
	output logic                               rw_data_strobe_oe_n,
	output logic                               busy
);
	localparam int IW = $clog2(WORDS);
	localparam int FW = psram_pkg::DATA_W + 1 + IW;

	typedef struct packed {
		psram_pkg::link_state_t   state;
		logic [2:0]               ca_cnt;
		logic [47:0]              ca;
		logic [4:0]               lat_cnt;
		logic [IW-1:0]            idx;
		logic [1:0]               sel_sync;
		logic [1:0]               rst_sync;
		logic [7:0]               rdata;
		psram_pkg::pin_out_t      pins;
	} link_t;

	typedef struct packed {
		logic [1:0] b1;
		logic       busy;
	} core_t;

	link_t                              l_ff;
	link_t                              nxt_l;
	core_t                              c_ff;
	core_t                              nxt_c;
	logic [psram_pkg::DATA_W-1:0]       mem_ff [WORDS];
	logic                               sel_evt_ff;
	logic                               ps_clk;
	logic                               lk_clk;
	logic                               wq_valid;
	logic                               wq_ready;
	logic [FW-1:0]                      wq_data;
	logic                               wo_valid;
	logic [FW-1:0]                      wo_data;
	logic                               rd_strobe_ff;
	logic                               rd_strobe_en_ff;

	localparam int XW = $clog2(DEPTH);
	logic [FW-1:0]                      xq_ff [DEPTH];
	logic [XW:0]                        xw_bin_ff;
	logic [XW:0]                        xw_gray_ff;
	logic [XW:0]                        xw_s1_ff;
	logic [XW:0]                        xw_s2_ff;
	logic [XW:0]                        xr_bin_ff;
	logic                               xq_avail;
	logic [FW-1:0]                      xq_data;

	initial begin
		if (WORDS < 2 || (1 << IW) != WORDS)
			$error("psram_link words must be a power of two");
	end

	function automatic logic [4:0] lat_total(input logic extra);
		lat_total = 5'(psram_pkg::LAT_CLOCKS * psram_pkg::LAT_MULT * 2);
	endfunction : lat_total

	function automatic logic [XW:0] to_gray(input logic [XW:0] b);
		to_gray = b ^ (b >> 1);
	endfunction : to_gray

	// Differential crossing or single true edge; both edge senses carry data
	assign lk_clk = diff_clock_en ? (bus_clock & ~bus_clock_comp)
		: bus_clock;
	assign ps_clk = diff_clock_en ? (shifted_clock & ~shifted_clock_comp)
		: shifted_clock;

	// Link side: runs only on bus clock edges, never on clk
	always_comb begin
		nxt_l = l_ff;
		nxt_l.sel_sync = {l_ff.sel_sync[0], 1'b1};
		case (l_ff.state)
			psram_pkg::ST_IDLE: begin
				nxt_l.state = psram_pkg::ST_CA;
				nxt_l.ca = {l_ff.ca[39:0], dq_i};
				nxt_l.ca_cnt = 3'h1;
				nxt_l.pins.ds_o = psram_pkg::STROBE_LAT2X;
				nxt_l.pins.ds_oe_n = 1'b0;
			end
			psram_pkg::ST_CA: begin
				nxt_l.ca = {l_ff.ca[39:0], dq_i};
				nxt_l.ca_cnt = l_ff.ca_cnt + 3'h1;
				if (l_ff.ca_cnt == 3'(psram_pkg::CA_BYTES - 1)) begin
					nxt_l.state = psram_pkg::ST_LAT;
					nxt_l.lat_cnt = lat_total(l_ff.pins.ds_o);
					nxt_l.pins.ds_oe_n = !l_ff.ca[39];
				end
			end
			psram_pkg::ST_LAT: begin
				nxt_l.lat_cnt = l_ff.lat_cnt - 5'h1;
				nxt_l.idx = l_ff.ca[IW-1+16:16];
				if (l_ff.lat_cnt == 5'h1)
					nxt_l.state = l_ff.ca[47] ? psram_pkg::ST_RD
						: psram_pkg::ST_WR;
				if (l_ff.lat_cnt == 5'h1 && l_ff.ca[47]) begin
					nxt_l.pins.dq_oe_n = 1'b0;
					nxt_l.pins.ds_oe_n = 1'b0;
				end
			end
			psram_pkg::ST_RD: begin
				nxt_l.pins.dq_o = mem_ff[l_ff.idx];
				nxt_l.idx = l_ff.idx + 1'b1;
				nxt_l.ca_cnt = l_ff.ca_cnt + 3'h1;
			end
			psram_pkg::ST_WR: begin
				nxt_l.idx = l_ff.idx + 1'b1;
			end
			default: nxt_l.state = psram_pkg::ST_DONE;
		endcase
	end

	// Reset and select both end the frame asynchronously; clock may stop
	always_ff @(posedge lk_clk or negedge lk_clk or posedge select_n
		or negedge rst_n) begin
		if (!rst_n || select_n) begin
			l_ff <= '0;
			l_ff.pins.dq_oe_n <= 1'b1;
			l_ff.pins.ds_oe_n <= 1'b1;
		end else
			l_ff <= nxt_l;
	end

	// Write bytes cross to clk through the FIFO
	assign wq_valid = (l_ff.state == psram_pkg::ST_WR)
		&& !rw_data_strobe_i;
	assign wq_data = {1'b1, l_ff.idx, dq_i};

	// Gray-pointer staging; no back-pressure at the pins, so a frame
	// must not leave more than DEPTH bytes undrained
	always_ff @(posedge lk_clk or negedge lk_clk or negedge rst_n) begin
		if (!rst_n) begin
			xw_bin_ff  <= '0;
			xw_gray_ff <= '0;
		end else if (wq_valid) begin
			xw_bin_ff  <= xw_bin_ff + 1'b1;
			xw_gray_ff <= to_gray(xw_bin_ff + 1'b1);
		end
	end

	always_ff @(posedge lk_clk or negedge lk_clk) begin
		if (wq_valid)
			xq_ff[xw_bin_ff[XW-1:0]] <= wq_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xw_s1_ff  <= '0;
			xw_s2_ff  <= '0;
			xr_bin_ff <= '0;
		end else begin
			xw_s1_ff <= xw_gray_ff;
			xw_s2_ff <= xw_s1_ff;
			if (xq_avail && wq_ready)
				xr_bin_ff <= xr_bin_ff + 1'b1;
		end
	end

	assign xq_avail = to_gray(xr_bin_ff) != xw_s2_ff;
	assign xq_data  = xq_ff[xr_bin_ff[XW-1:0]];

	word_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_wq (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (xq_avail),
		.in_ready  (wq_ready),
		.in_data   (xq_data),
		.out_valid (wo_valid),
		.out_ready (1'b1),
		.out_data  (wo_data)
	);

	always_ff @(posedge clk) begin
		if (wo_valid && wo_data[FW-1])
			mem_ff[wo_data[FW-2:8]] <= wo_data[7:0];
	end

	// Select level into clk domain
	always_comb begin
		nxt_c.b1   = {c_ff.b1[0], select_n};
		nxt_c.busy = !c_ff.b1[1] || wo_valid || xq_avail;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			c_ff <= '{b1: 2'h3, busy: 1'b0};
		else
			c_ff <= nxt_c;
	end

	// Read strobe follows the shifted clock when the option is fitted
	always_ff @(posedge ps_clk or negedge ps_clk or posedge select_n
		or negedge rst_n) begin
		if (!rst_n || select_n) begin
			rd_strobe_ff    <= 1'b0;
			rd_strobe_en_ff <= 1'b0;
		end else begin
			rd_strobe_en_ff <= l_ff.state == psram_pkg::ST_RD;
			rd_strobe_ff    <= ps_clk;
		end
	end

	assign sel_evt_ff          = c_ff.b1[1];
	assign dq_o                = l_ff.pins.dq_o;
	assign dq_oe_n             = l_ff.pins.dq_oe_n;
	assign rw_data_strobe_oe_n = l_ff.pins.ds_oe_n;
	assign rw_data_strobe_o    = (l_ff.state == psram_pkg::ST_RD)
		? (centered_read_strobe_option ? rd_strobe_ff : l_ff.ca_cnt[0])
		: l_ff.pins.ds_o;
	assign busy                = c_ff.busy;

	reset_release_a: assert property (@(posedge clk)
		!rst_n |-> dq_oe_n && rw_data_strobe_oe_n)
		else $error("pins driven in reset");
	idle_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		select_n |-> ##1 dq_oe_n)
		else $error("data driven without select");
	lat_flag_a: assert property (@(posedge lk_clk) disable iff (!rst_n)
		l_ff.state == psram_pkg::ST_CA && l_ff.ca_cnt == 3'h1
		|-> rw_data_strobe_o == psram_pkg::STROBE_LAT2X)
		else $error("latency flag wrong");
	lat_load_a: assert property (@(posedge lk_clk) disable iff (!rst_n)
		$rose(l_ff.state == psram_pkg::ST_LAT) |-> l_ff.lat_cnt == 5'h10)
		else $error("latency not doubled");
	wr_no_drive_a: assert property (@(posedge lk_clk) disable iff (!rst_n)
		l_ff.state == psram_pkg::ST_WR |-> dq_oe_n && rw_data_strobe_oe_n)
		else $error("driven during write");
	rd_drive_a: assert property (@(posedge lk_clk) disable iff (!rst_n)
		l_ff.state == psram_pkg::ST_RD |-> !dq_oe_n && !rw_data_strobe_oe_n)
		else $error("read not driven");
	mask_drop_a: assert property (@(posedge lk_clk) disable iff (!rst_n)
		rw_data_strobe_i && l_ff.state == psram_pkg::ST_WR |-> !wq_valid)
		else $error("masked byte queued");
	busy_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
		!select_n [*4] |-> busy)
		else $error("busy not following select");
endmodule : psram_link

//--- common/psram_pkg.sv
package psram_pkg;

	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 32;
	localparam int          CA_BYTES        = 6;
	localparam logic [3:0]  LAT_CLOCKS      = 4'h4;
	localparam logic [1:0]  LAT_MULT        = 2'h2;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          MEM_WORDS       = 64;
	localparam int          CSM_85_US       = 4;
	localparam int          CSM_105_US      = 1;
	localparam int          CLK_MHZ         = 40;
	localparam int          CSM_85_CYC      = CSM_85_US * CLK_MHZ;
	localparam int          CSM_105_CYC     = CSM_105_US * CLK_MHZ;
	localparam logic        STROBE_LAT2X    = 1'b1;
	localparam logic [7:0]  RD_FILL         = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CA    = 3'b001,
		ST_LAT   = 3'b011,
		ST_RD    = 3'b010,
		ST_WR    = 3'b110,
		ST_DONE  = 3'b111
	} link_state_t;

	typedef struct packed {
		logic                 wr;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    data;
	} mem_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]    dq_o;
		logic                 dq_oe_n;
		logic                 ds_o;
		logic                 ds_oe_n;
	} pin_out_t;

endpackage : psram_pkg

//--- logic/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fifo_state_t;

	fifo_state_t           st_ff;
	fifo_state_t           nxt_st;
	logic [WIDTH-1:0]      mem_ff [DEPTH];
	logic                  do_wr;
	logic                  do_rd;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("word_fifo depth must be a power of two");
	end

	assign in_ready  = (st_ff.wp - st_ff.rp) != (AW+1)'(DEPTH);
	assign out_valid = st_ff.wp != st_ff.rp;
	assign out_data  = mem_ff[st_ff.rp[AW-1:0]];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always_comb begin
		nxt_st = st_ff;
		if (do_wr)
			nxt_st.wp = st_ff.wp + 1'b1;
		if (do_rd)
			nxt_st.rp = st_ff.rp + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	always_ff @(posedge clk) begin
		if (do_wr)
			mem_ff[st_ff.wp[AW-1:0]] <= in_data;
	end

	fill_level_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff.wp - st_ff.rp) <= (AW+1)'(DEPTH))
		else $error("fifo over-filled");
	no_underflow_a: assert property (@(posedge clk) disable iff (!rst_n)
		!out_valid |-> ##1 (st_ff.rp == $past(st_ff.rp)))
		else $error("fifo read while empty");
endmodule : word_fifo

//--- test/bus_host.sv
`timescale 1ns/100ps
module bus_host (
	output logic       bus_clock,
	output logic       bus_clock_comp,
	output logic       shifted_clock,
	output logic       shifted_clock_comp,
	output logic       select_n,
	output logic [7:0] dq_i,
	output logic       rw_data_strobe_i,
	input  wire logic  diff_clock_en,
	input  wire logic  [7:0] dq_o,
	input  wire logic  dq_oe_n,
	input  wire logic  rw_data_strobe_o,
	input  wire logic  rw_data_strobe_oe_n
);
	localparam int LAT_E = 2 * psram_pkg::LAT_CLOCKS * psram_pkg::LAT_MULT;
	logic [7:0] wbuf [16];
	logic       wmsk [16];
	logic [7:0] rbuf [16];
	logic       lat_seen;
	logic       in_rd;
	int         n_tog;

	// Released lines flip so a stale value never looks valid
	initial begin
		{bus_clock, shifted_clock, shifted_clock_comp} = 3'h0;
		bus_clock_comp = 1'b1;
		select_n = 1'b1;
		dq_i = 8'h5A;
		rw_data_strobe_i = 1'b0;
		in_rd = 1'b0;
	end

	always @(rw_data_strobe_o) begin
		if (in_rd && !rw_data_strobe_oe_n)
			n_tog++;
	end

	// Clock stands still between calls; 16 ns is 90 degrees
	task automatic step(input logic rd);
		bus_clock = ~bus_clock;
		bus_clock_comp = ~bus_clock;
		#16;
		shifted_clock = rd & bus_clock;
		shifted_clock_comp = rd & diff_clock_en & ~bus_clock;
		#16;
	endtask : step

	task automatic xfer(input logic rd, input int n);
		int j;
		n_tog = 0;
		select_n = 1'b0;
		for (int i = 0; i < 6 + LAT_E + n; i++) begin
			j = i - 6 - LAT_E;
			if (i < 6)
				dq_i = (i == 0) ? {rd, 1'b1, 6'h00} : 8'h00;
			else if (rd || j < 0)
				dq_i = ~dq_i;
			else
				dq_i = wbuf[j];
			rw_data_strobe_i = (!rd && j >= 0) ? wmsk[j] : ~rw_data_strobe_i;
			in_rd = rd && j >= 0;
			step(rd);
			if (i == 0)
				lat_seen = rw_data_strobe_o & ~rw_data_strobe_oe_n;
			if (in_rd)
				rbuf[j] = dq_oe_n ? 'x : dq_o;
		end
		#32;
		in_rd = 1'b0;
		select_n = 1'b1;
		{shifted_clock, shifted_clock_comp} = 2'h0;
		#64;
	endtask : xfer
endmodule : bus_host

//--- test/ddr_psram_strobe_bus_if_tb_top.sv
`timescale 1ns/100ps
module ddr_psram_strobe_bus_if_tb_top;
	logic       clk, rst_n, diff_clock_en, centered, busy;
	logic       bc, bcc, sc, scc, select_n, ds_i, ds_o, ds_oe_n, dq_oe_n;
	logic [7:0] dq_i, dq_o;
	logic [7:0] mem [16];
	int         n_fail, n_compared, n;

	psram_link #(.WORDS(psram_pkg::MEM_WORDS), .DEPTH(16)) dut_u (
		.clk(clk), .rst_n(rst_n), .bus_clock(bc), .bus_clock_comp(bcc),
		.shifted_clock(sc), .shifted_clock_comp(scc), .select_n(select_n),
		.diff_clock_en(diff_clock_en),
		.centered_read_strobe_option(centered), .dq_i(dq_i),
		.rw_data_strobe_i(ds_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
		.rw_data_strobe_o(ds_o), .rw_data_strobe_oe_n(ds_oe_n), .busy(busy));

	bus_host host_u (
		.bus_clock(bc), .bus_clock_comp(bcc), .shifted_clock(sc),
		.shifted_clock_comp(scc), .select_n(select_n), .dq_i(dq_i),
		.rw_data_strobe_i(ds_i), .diff_clock_en(diff_clock_en), .dq_o(dq_o),
		.dq_oe_n(dq_oe_n), .rw_data_strobe_o(ds_o),
		.rw_data_strobe_oe_n(ds_oe_n));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic fill(input int cnt, input logic masked);
		for (int i = 0; i < 16; i++) begin
			host_u.wbuf[i] = 8'($urandom);
			host_u.wmsk[i] = masked & 1'($urandom_range(1));
			if (i < cnt && !host_u.wmsk[i])
				mem[i] = host_u.wbuf[i];
		end
	endtask : fill

	task automatic frame(input logic rd, input int cnt);
		host_u.xfer(rd, cnt);
		chk({7'h00, host_u.lat_seen}, {7'h00, psram_pkg::STROBE_LAT2X}, "lat");
		repeat (20) @(posedge clk);
		chk({6'h00, dq_oe_n, ds_oe_n}, 8'h03, "released");
		chk({7'h00, busy}, 8'h00, "busy");
		if (rd) begin
			chk(8'(host_u.n_tog), 8'(cnt), "strobe edges");
			for (int i = 0; i < cnt; i++)
				chk(host_u.rbuf[i], mem[i], "read byte");
		end
	endtask : frame

	initial begin
		{rst_n, diff_clock_en, centered} = 3'h0;
		void'($urandom(86));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		fill(16, 1'b0);
		frame(1'b0, 16);
		frame(1'b1, 16);
		$display("test full burst done");
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			diff_clock_en <= m[0];
			centered <= m[1];
			n = 2 * (1 + $urandom_range(7));
			fill(n, 1'b1);
			frame(1'b0, n);
			frame(1'b1, n);
			$display("test mode %0d done", m);
		end
		// Reset lands inside a read data phase
		fork
			host_u.xfer(1'b1, 16);
			begin
				#800;
				@(posedge clk);
				rst_n <= 1'b0;
				@(negedge clk);
				chk({6'h00, dq_oe_n, ds_oe_n}, 8'h03, "reset release");
			end
		join
		@(posedge clk);
		rst_n <= 1'b1;
		$display("test reset done");
		end_of_test();
	end

	initial begin
		#60000;
		n_fail++;
		$display("BAD t=%0t run hung", $time);
		end_of_test();
	end
endmodule : ddr_psram_strobe_bus_if_tb_top
